// ### jlc_pkg.sv
package jlc_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IDX_W  = 10;
	localparam int unsigned REG_W  = 8;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_B4_TRIM_ZERO  = 10'h142;
	localparam logic [IDX_W-1:0] IDX_B4_TRIM_M90   = 10'h143;
	localparam logic [IDX_W-1:0] IDX_B5_TRIM_ZERO  = 10'h152;
	localparam logic [IDX_W-1:0] IDX_B5_TRIM_M90   = 10'h153;
	localparam logic [IDX_W-1:0] IDX_LSB_MARKER    = 10'h160;
	localparam logic [IDX_W-1:0] IDX_RSV_LO        = 10'h161;
	localparam logic [IDX_W-1:0] IDX_RSV_HI        = 10'h1FF;
	localparam logic [IDX_W-1:0] IDX_LINK_ENABLE   = 10'h200;
	localparam logic [IDX_W-1:0] IDX_OUTPUT_MODE   = 10'h201;
	localparam logic [IDX_W-1:0] IDX_FRAMES_LESS1  = 10'h202;
	localparam logic [IDX_W-1:0] IDX_SW_SYNC       = 10'h203;
	localparam logic [IDX_W-1:0] IDX_LINK_CONTROL  = 10'h204;
	localparam logic [IDX_W-1:0] IDX_TEST_PATTERN  = 10'h205;
	localparam logic [IDX_W-1:0] IDX_DEVICE_ID     = 10'h206;
	localparam logic [IDX_W-1:0] IDX_FRAME_CHAR    = 10'h207;
	localparam logic [IDX_W-1:0] IDX_SYSTEM_STATUS = 10'h208;
	localparam logic [IDX_W-1:0] IDX_CH_POWER_DOWN = 10'h209;
	localparam logic [IDX_W-1:0] IDX_EXTRA_FIRST   = 10'h20A;
	localparam logic [IDX_W-1:0] IDX_EXTRA_SECOND  = 10'h20B;

	// ----------------------------------------------------------------
	// Reset values and writable-bit masks
	// ----------------------------------------------------------------
	localparam logic [REG_W-1:0] RST_LSB_MARKER   = 8'h00;
	localparam logic [REG_W-1:0] RST_LINK_ENABLE  = 8'h01;
	localparam logic [REG_W-1:0] RST_OUTPUT_MODE  = 8'h02;
	localparam logic [REG_W-1:0] RST_FRAMES_LESS1 = 8'h1F;
	localparam logic [REG_W-1:0] RST_SW_SYNC      = 8'h01;
	localparam logic [REG_W-1:0] RST_LINK_CONTROL = 8'h02;
	localparam logic [REG_W-1:0] RST_ZERO         = 8'h00;
	localparam logic [REG_W-1:0] MASK_BIT0        = 8'h01;
	localparam logic [REG_W-1:0] MASK_LOW5        = 8'h1F;
	localparam logic [REG_W-1:0] MASK_LOW4        = 8'h0F;
	localparam logic [REG_W-1:0] MASK_ALL         = 8'hFF;

	// ----------------------------------------------------------------
	// Field positions and timing
	// ----------------------------------------------------------------
	localparam int unsigned BIT_MARKER_EN    = 0;
	localparam int unsigned BIT_LINK_EN      = 0;
	localparam int unsigned BIT_STAT_LINK    = 0;
	localparam int unsigned BIT_STAT_ALIGNED = 1;
	localparam int unsigned SYNC_STAGES      = 3;
	localparam int unsigned MARK_LATENCY     = 4;
	localparam logic [1:0]  ILA_CS_VALUE     = 2'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_state_t;

	typedef struct packed {
		logic [REG_W-1:0] b4_zero;
		logic [REG_W-1:0] b4_m90;
		logic [REG_W-1:0] b5_zero;
		logic [REG_W-1:0] b5_m90;
	} trim_set_t;

	typedef struct packed {
		logic [REG_W-1:0] output_mode;
		logic [REG_W-1:0] frames_less1;
		logic [REG_W-1:0] sw_sync;
		logic [REG_W-1:0] control;
		logic [REG_W-1:0] test_pattern;
		logic [REG_W-1:0] device_id;
		logic [REG_W-1:0] frame_char;
		logic [REG_W-1:0] power_down;
		logic [REG_W-1:0] extra_first;
		logic [REG_W-1:0] extra_second;
	} link_cfg_t;

endpackage

// ### jesd_link_control_regs.sv
// What this block does
// R1: Each bank 4 and bank 5 trim register is eight bits, and the zero or minus-ninety one is used per clock phase.
// R2: Trim registers load the factory trim after reset and software may then overwrite them.
// R3: With the marker enable bit set, the marker replaces the sample LSB; the bit resets to zero.
// R4: When marker and calibration-state output are both enabled, the marker wins the LSB.
// R5: Whoever enables the marker must also turn on the marker input receiver.
// R6: The marker travels with exactly the same latency as the samples it marks.
// R7: The control-bit count announced in lane alignment is always zero.
// R8: Bit 0 of the link enable register turns the serial link on when one and resets to one.
// R9: Software clears link enable before touching any other link configuration register.
// R10: With link enable low the link logic is held in reset and the serializers are powered down.
// R11: With link enable low the link logic clocks are gated off.
// R12: With link enable low the multiframe counter is held in reset and SYSREF cannot realign it.
// R13: Software sets calibration enable before it sets link enable.
// R14: Software clears link enable before it clears calibration enable.
// R15: Reads in the reserved range after the LSB control register return no defined value.
// R16: Writes to reserved addresses or reserved bits change nothing.
module jesd_link_control_regs
	import jlc_pkg::*;
#(
	parameter int unsigned SAMPLE_W = 8
)(
	input  wire logic                clk_i,
	input  wire logic                rstn_i,
	input  wire logic [ADDR_W-1:0]   address_i,
	input  wire logic                read_i,
	input  wire logic                write_i,
	input  wire logic [DATA_W-1:0]   writedata_i,
	input  wire logic [3:0]          byteenable_i,
	output logic      [DATA_W-1:0]   readdata_o,
	output logic                     waitrequest_o,
	input  wire trim_set_t           factory_trim_i,
	input  wire logic                phase_minus90_i,
	output logic      [REG_W-1:0]    bank4_trim_o,
	output logic      [REG_W-1:0]    bank5_trim_o,
	input  wire logic [SAMPLE_W-1:0] sample_i,
	input  wire logic                cal_state_i,
	input  wire logic                cal_state_en_i,
	input  wire logic                marker_i,
	output logic      [SAMPLE_W-1:0] sample_o,
	output logic      [1:0]          ila_cs_o,
	input  wire logic                sysref_i,
	output logic                     link_rstn_o,
	output logic                     serdes_pd_o,
	output logic                     link_clk_en_o,
	output logic      [4:0]          lmfc_count_o,
	output link_cfg_t                link_cfg_o
);

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic [REG_W-1:0] wmask(input logic [IDX_W-1:0] idx);
		case (idx)
			IDX_B4_TRIM_ZERO, IDX_B4_TRIM_M90,
			IDX_B5_TRIM_ZERO, IDX_B5_TRIM_M90,
			IDX_DEVICE_ID, IDX_FRAME_CHAR,
			IDX_EXTRA_FIRST, IDX_EXTRA_SECOND:     wmask = MASK_ALL;
			IDX_LSB_MARKER, IDX_LINK_ENABLE,
			IDX_SW_SYNC:                           wmask = MASK_BIT0;
			IDX_OUTPUT_MODE, IDX_FRAMES_LESS1:     wmask = MASK_LOW5;
			IDX_LINK_CONTROL, IDX_TEST_PATTERN,
			IDX_CH_POWER_DOWN:                     wmask = MASK_LOW4;
			default:                               wmask = RST_ZERO;
		endcase
	endfunction

	function automatic logic is_reserved(input logic [IDX_W-1:0] idx);
		is_reserved = (wmask(idx) == RST_ZERO) && (idx != IDX_SYSTEM_STATUS);
	endfunction

	bus_state_t       state;
	trim_set_t        trim;
	link_cfg_t        cfg;
	logic [REG_W-1:0] marker_ctrl;
	logic [REG_W-1:0] link_enable;
	logic             aligned_flag;
	logic             trim_loaded;
	logic [IDX_W-1:0] idx;
	logic [REG_W-1:0] wdat;
	logic             wr_fire;
	logic [REG_W-1:0] rd_val;
	logic             link_en;
	logic             marker_en;

	assign idx       = address_i[ADDR_W-1:2];
	assign wdat      = writedata_i[REG_W-1:0] & wmask(idx); // [R16]
	assign wr_fire   = write_i && (state == BUS_ACK) && byteenable_i[0];
	assign link_en   = link_enable[BIT_LINK_EN];
	assign marker_en = marker_ctrl[BIT_MARKER_EN];

	// ----------------------------------------------------------------
	// Avalon slave: one wait state on every access
	// ----------------------------------------------------------------
	assign waitrequest_o = (read_i || write_i) && (state != BUS_ACK);

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			state <= BUS_IDLE;
		else
			case (state)
				BUS_IDLE: state <= (read_i || write_i) ? BUS_ACK : BUS_IDLE;
				BUS_ACK:  state <= BUS_IDLE;
				default:  state <= BUS_IDLE;
			endcase
	end

	always_comb
	begin
		case (idx)
			IDX_B4_TRIM_ZERO:  rd_val = trim.b4_zero;
			IDX_B4_TRIM_M90:   rd_val = trim.b4_m90;
			IDX_B5_TRIM_ZERO:  rd_val = trim.b5_zero;
			IDX_B5_TRIM_M90:   rd_val = trim.b5_m90;
			IDX_LSB_MARKER:    rd_val = marker_ctrl;
			IDX_LINK_ENABLE:   rd_val = link_enable;
			IDX_OUTPUT_MODE:   rd_val = cfg.output_mode;
			IDX_FRAMES_LESS1:  rd_val = cfg.frames_less1;
			IDX_SW_SYNC:       rd_val = cfg.sw_sync;
			IDX_LINK_CONTROL:  rd_val = cfg.control;
			IDX_TEST_PATTERN:  rd_val = cfg.test_pattern;
			IDX_DEVICE_ID:     rd_val = cfg.device_id;
			IDX_FRAME_CHAR:    rd_val = cfg.frame_char;
			IDX_SYSTEM_STATUS: rd_val = {6'h00, aligned_flag, link_en};
			IDX_CH_POWER_DOWN: rd_val = cfg.power_down;
			IDX_EXTRA_FIRST:   rd_val = cfg.extra_first;
			IDX_EXTRA_SECOND:  rd_val = cfg.extra_second;
			// Reserved range answers zero; software must not rely on it
			default:           rd_val = RST_ZERO; // [R15]
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			readdata_o <= '0;
		else if (read_i && (state == BUS_IDLE))
			readdata_o <= {{(DATA_W-REG_W){1'b0}}, rd_val};
	end

	// ----------------------------------------------------------------
	// Trim registers
	// ----------------------------------------------------------------
	// Factory values come in after release, never through the async reset
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			trim        <= '0;
			trim_loaded <= 1'b0;
		end
		else if (!trim_loaded)
		begin
			trim        <= factory_trim_i; // [R2]
			trim_loaded <= 1'b1;
		end
		else if (wr_fire)
			case (idx)
				IDX_B4_TRIM_ZERO: trim.b4_zero <= wdat; // [R2]
				IDX_B4_TRIM_M90:  trim.b4_m90  <= wdat;
				IDX_B5_TRIM_ZERO: trim.b5_zero <= wdat;
				IDX_B5_TRIM_M90:  trim.b5_m90  <= wdat;
				default:          trim         <= trim;
			endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			bank4_trim_o <= '0;
			bank5_trim_o <= '0;
		end
		else
		begin
			bank4_trim_o <= phase_minus90_i ? trim.b4_m90 : trim.b4_zero; // [R1]
			bank5_trim_o <= phase_minus90_i ? trim.b5_m90 : trim.b5_zero; // [R1]
		end
	end

	// ----------------------------------------------------------------
	// Marker, link enable and link configuration
	// ----------------------------------------------------------------
	// Link settings are stored even while the link runs; keeping the
	// link disabled during changes is left to software [R9]
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			marker_ctrl      <= RST_LSB_MARKER; // [R3]
			link_enable      <= RST_LINK_ENABLE; // [R8]
			cfg              <= '0;
			cfg.output_mode  <= RST_OUTPUT_MODE;
			cfg.frames_less1 <= RST_FRAMES_LESS1;
			cfg.sw_sync      <= RST_SW_SYNC;
			cfg.control      <= RST_LINK_CONTROL;
		end
		else if (wr_fire)
			case (idx)
				IDX_LSB_MARKER:    marker_ctrl      <= wdat; // [R3]
				IDX_LINK_ENABLE:   link_enable      <= wdat; // [R8]
				IDX_OUTPUT_MODE:   cfg.output_mode  <= wdat;
				IDX_FRAMES_LESS1:  cfg.frames_less1 <= wdat;
				IDX_SW_SYNC:       cfg.sw_sync      <= wdat;
				IDX_LINK_CONTROL:  cfg.control      <= wdat;
				IDX_TEST_PATTERN:  cfg.test_pattern <= wdat;
				IDX_DEVICE_ID:     cfg.device_id    <= wdat;
				IDX_FRAME_CHAR:    cfg.frame_char   <= wdat;
				IDX_CH_POWER_DOWN: cfg.power_down   <= wdat;
				IDX_EXTRA_FIRST:   cfg.extra_first  <= wdat;
				IDX_EXTRA_SECOND:  cfg.extra_second <= wdat;
				default:           cfg              <= cfg; // [R16]
			endcase
	end

	assign link_cfg_o = cfg;

	// ----------------------------------------------------------------
	// Link power, reset and clock gating
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			link_rstn_o   <= 1'b0;
			serdes_pd_o   <= 1'b1;
			link_clk_en_o <= 1'b0;
			ila_cs_o      <= ILA_CS_VALUE;
		end
		else
		begin
			link_rstn_o   <= link_en; // [R10]
			serdes_pd_o   <= !link_en; // [R10]
			link_clk_en_o <= link_en; // [R11]
			ila_cs_o      <= ILA_CS_VALUE; // [R7]
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers (change taken when stages two and three agree)
	// ----------------------------------------------------------------
	logic [SYNC_STAGES-1:0] mark_sync;
	logic [SYNC_STAGES-1:0] sysref_sync;
	logic                   mark_level;
	logic                   sysref_level;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			mark_sync    <= '0;
			sysref_sync  <= '0;
			mark_level   <= 1'b0;
			sysref_level <= 1'b0;
		end
		else
		begin
			mark_sync   <= {mark_sync[SYNC_STAGES-2:0], marker_i};
			sysref_sync <= {sysref_sync[SYNC_STAGES-2:0], sysref_i};
			if (mark_sync[1] == mark_sync[2])
				mark_level <= mark_sync[2];
			if (sysref_sync[1] == sysref_sync[2])
				sysref_level <= sysref_sync[2];
		end
	end

	// ----------------------------------------------------------------
	// Multiframe counter
	// ----------------------------------------------------------------
	logic sysref_prev;
	logic realign;

	assign realign = sysref_level && !sysref_prev && link_en; // [R12]

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sysref_prev  <= 1'b0;
			lmfc_count_o <= '0;
		end
		else
		begin
			sysref_prev <= sysref_level;
			if (!link_en || realign)
				lmfc_count_o <= '0; // [R12]
			else if (lmfc_count_o == cfg.frames_less1[4:0])
				lmfc_count_o <= '0;
			else
				lmfc_count_o <= lmfc_count_o + 5'h01;
		end
	end

	// Sticky alignment flag, write one to clear; a new alignment wins
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			aligned_flag <= 1'b0;
		else if (realign)
			aligned_flag <= 1'b1;
		else if (wr_fire && (idx == IDX_SYSTEM_STATUS) && writedata_i[BIT_STAT_ALIGNED])
			aligned_flag <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Sample path: samples wait as long as the marker synchroniser
	// ----------------------------------------------------------------
	logic [SAMPLE_W:0] pipe [MARK_LATENCY];
	logic [SAMPLE_W:0] pipe_out;
	logic              lsb;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			pipe[0] <= '0;
		else
			pipe[0] <= {cal_state_i, sample_i};
	end

	for (genvar g = 1; g < MARK_LATENCY; g++)
	begin : g_pipe
		always_ff @(posedge clk_i or negedge rstn_i)
		begin
			if (!rstn_i)
				pipe[g] <= '0;
			else
				pipe[g] <= pipe[g-1]; // [R6]
		end
	end

	assign pipe_out = pipe[MARK_LATENCY-1];
	// Marker first, then calibration state, else the sample's own LSB
	assign lsb = marker_en      ? mark_level : // [R4]
	             cal_state_en_i ? pipe_out[SAMPLE_W] : pipe_out[0]; // [R3]

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			sample_o <= '0;
		else if (!link_en)
			sample_o <= '0;
		else
			sample_o <= {pipe_out[SAMPLE_W-1:1], lsb}; // [R6]
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_trim_phase_select: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R1]
		phase_minus90_i |=> (bank4_trim_o == $past(trim.b4_m90)) && (bank5_trim_o == $past(trim.b5_m90)))
		else $error("trim output not taken from the minus-ninety register");

	chk_factory_trim_load: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R2]
		!trim_loaded |=> trim_loaded && (trim == $past(factory_trim_i)))
		else $error("factory trim not loaded after reset");

	chk_reset_values: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R8]
		!trim_loaded |-> link_en && !marker_en && (cfg.frames_less1 == RST_FRAMES_LESS1))
		else $error("register reset value wrong");

	chk_sample_passthru: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R3]
		(link_en && $past(link_en) && !$past(marker_en) && !$past(cal_state_en_i) && trim_loaded
		 && $past(trim_loaded, 5))
		|-> sample_o == $past(sample_i, 5))
		else $error("sample not passed with fixed latency");

	chk_marker_priority: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R4]
		(link_en && marker_en && cal_state_en_i) |=> sample_o[0] == $past(mark_level))
		else $error("calibration state took the LSB over the marker");

	chk_marker_latency: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R6]
		(link_en && $past(link_en) && marker_en && $past(marker_en) && $past(trim_loaded, 5)
		 && ($past(marker_i, 5) == $past(marker_i, 4)))
		|-> sample_o[0] == $past(marker_i, 5))
		else $error("marker out of step with its sample");

	chk_ila_cs_zero: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R7]
		ila_cs_o == 2'h0)
		else $error("control-bit count announced as nonzero");

	chk_link_held: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R10]
		!link_en |=> !link_rstn_o && serdes_pd_o)
		else $error("link not held in reset while disabled");

	chk_clock_gated: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R11]
		!link_en ##1 !link_en |-> !link_clk_en_o)
		else $error("link clock running while disabled");

	chk_lmfc_held: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R12]
		!link_en |=> (lmfc_count_o == 5'h00) && !$rose(aligned_flag))
		else $error("multiframe counter moved while disabled");

	chk_reserved_write: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R16]
		(wr_fire && is_reserved(idx)) |=> $stable(cfg) && $stable(marker_ctrl) && $stable(link_enable))
		else $error("write to reserved address changed state");

endmodule // jesd_link_control_regs

// ### jesd_link_control_regs_tb.sv
module jesd_link_control_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import jlc_pkg::*;

	logic              clk_i;
	logic              rstn_i;
	logic [ADDR_W-1:0] address_i;
	logic              read_i;
	logic              write_i;
	logic [DATA_W-1:0] writedata_i;
	logic [3:0]        byteenable_i;
	logic [DATA_W-1:0] readdata_o;
	logic              waitrequest_o;
	trim_set_t         factory_trim_i;
	logic              phase_minus90_i;
	logic [REG_W-1:0]  bank4_trim_o;
	logic [REG_W-1:0]  bank5_trim_o;
	logic [7:0]        sample_i;
	logic              cal_state_i;
	logic              cal_state_en_i;
	logic              marker_i;
	logic [7:0]        sample_o;
	logic [1:0]        ila_cs_o;
	logic              sysref_i;
	logic              link_rstn_o;
	logic              serdes_pd_o;
	logic              link_clk_en_o;
	logic [4:0]        lmfc_count_o;
	link_cfg_t         link_cfg_o;
	int                failures;
	int                num_checks;
	int                cycles;
	logic [DATA_W-1:0] rd;
	logic [IDX_W-1:0]  rst_idx [11] = '{IDX_LSB_MARKER, IDX_LINK_ENABLE, IDX_OUTPUT_MODE,
		IDX_FRAMES_LESS1, IDX_SW_SYNC, IDX_LINK_CONTROL, IDX_TEST_PATTERN, IDX_DEVICE_ID,
		IDX_FRAME_CHAR, IDX_CH_POWER_DOWN, IDX_EXTRA_FIRST};
	logic [REG_W-1:0]  rst_val [11] = '{8'h00, 8'h01, 8'h02, 8'h1F, 8'h01, 8'h02, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00};

	jesd_link_control_regs #(
		.SAMPLE_W (8)
	) i_dut (
		.clk_i           (clk_i),
		.rstn_i          (rstn_i),
		.address_i       (address_i),
		.read_i          (read_i),
		.write_i         (write_i),
		.writedata_i     (writedata_i),
		.byteenable_i    (byteenable_i),
		.readdata_o      (readdata_o),
		.waitrequest_o   (waitrequest_o),
		.factory_trim_i  (factory_trim_i),
		.phase_minus90_i (phase_minus90_i),
		.bank4_trim_o    (bank4_trim_o),
		.bank5_trim_o    (bank5_trim_o),
		.sample_i        (sample_i),
		.cal_state_i     (cal_state_i),
		.cal_state_en_i  (cal_state_en_i),
		.marker_i        (marker_i),
		.sample_o        (sample_o),
		.ila_cs_o        (ila_cs_o),
		.sysref_i        (sysref_i),
		.link_rstn_o     (link_rstn_o),
		.serdes_pd_o     (serdes_pd_o),
		.link_clk_en_o   (link_clk_en_o),
		.lmfc_count_o    (lmfc_count_o),
		.link_cfg_o      (link_cfg_o)
	);

	// ----------------------------------------------------------------
	// Clock, timeout and reporting
	// ----------------------------------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Whole sequence needs well under a thousand cycles
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// ----------------------------------------------------------------
	// Avalon-MM master
	// ----------------------------------------------------------------
	// Request stands until a rising edge sees waitrequest low; data is taken there
	task automatic bus_cycle(input logic [IDX_W-1:0] idx, input logic wr,
		input logic [7:0] d, input logic [3:0] be);
		@(posedge clk_i);
		address_i    <= {idx, 2'b00};
		writedata_i  <= {24'h000000, d};
		byteenable_i <= be;
		read_i       <= ~wr;
		write_i      <= wr;
		do
			@(posedge clk_i);
		while (waitrequest_o !== 1'b0);
		rd = readdata_o;
		read_i  <= 1'b0;
		write_i <= 1'b0;
	endtask

	task automatic reg_wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
		bus_cycle(idx, 1'b1, d, 4'hF);
	endtask

	task automatic reg_rd_chk(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
		bus_cycle(idx, 1'b0, 8'h00, 4'hF);
		check(rd, {24'h000000, exp});
	endtask

	task automatic edges(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial
	begin
		rstn_i = 1'b0;
		address_i = '0;
		read_i = 1'b0;
		write_i = 1'b0;
		writedata_i = '0;
		byteenable_i = 4'h0;
		factory_trim_i = {8'h3C, 8'h5A, 8'hA5, 8'hC3};
		phase_minus90_i = 1'b0;
		sample_i = 8'h00;
		cal_state_i = 1'b1;
		cal_state_en_i = 1'b1;
		marker_i = 1'b0;
		sysref_i = 1'b0;
		failures = 0;
		num_checks = 0;
		cycles = 0;
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		edges(2);
		for (int i = 0; i < 11; i++)
			reg_rd_chk(rst_idx[i], rst_val[i]);
		reg_rd_chk(IDX_B4_TRIM_ZERO, 8'h3C);
		reg_rd_chk(IDX_B4_TRIM_M90, 8'h5A);
		reg_rd_chk(IDX_B5_TRIM_ZERO, 8'hA5);
		reg_rd_chk(IDX_B5_TRIM_M90, 8'hC3);
		check({bank4_trim_o, bank5_trim_o}, 16'h3CA5);
		phase_minus90_i <= 1'b1;
		edges(2);
		check({bank4_trim_o, bank5_trim_o}, 16'h5AC3);
		reg_wr(IDX_B4_TRIM_M90, 8'h77);
		reg_rd_chk(IDX_B4_TRIM_M90, 8'h77);
		edges(1);
		check(bank4_trim_o, 8'h77);
		// Reserved places, reserved bits and a disabled byte lane
		reg_wr(IDX_RSV_LO, 8'hFF);
		reg_rd_chk(IDX_RSV_LO, 8'h00);
		reg_rd_chk(IDX_RSV_HI, 8'h00);
		reg_rd_chk(10'h3FF, 8'h00);
		bus_cycle(IDX_LSB_MARKER, 1'b1, 8'h01, 4'hE);
		reg_rd_chk(IDX_LSB_MARKER, 8'h00);
		reg_wr(IDX_LINK_ENABLE, 8'hFF);
		reg_rd_chk(IDX_LINK_ENABLE, 8'h01);
		// Calibration-state bit owns the LSB while the marker is off
		edges(6);
		check(sample_o[0], 1'b1);
		// Marker on; the receiver enable has no pin here
		reg_wr(IDX_LSB_MARKER, 8'hFF);
		reg_rd_chk(IDX_LSB_MARKER, 8'h01);
		@(posedge clk_i);
		sample_i <= 8'hA2;
		marker_i <= 1'b1;
		edges(3);
		check(sample_o[7:1], 7'h00);
		@(posedge clk_i);
		sample_i <= 8'h00;
		marker_i <= 1'b0;
		edges(1);
		check(sample_o[7:1], 7'h51);
		edges(1);
		check(sample_o, 8'hA3);
		edges(1);
		check(sample_o, 8'hA3);
		edges(3);
		check(sample_o, 8'h00);
		check(ila_cs_o, 2'h0);
		// Marker and calibration state both off: the sample keeps its own LSB
		reg_wr(IDX_LSB_MARKER, 8'h00);
		@(posedge clk_i);
		cal_state_en_i <= 1'b0;
		sample_i <= 8'h5B;
		edges(6);
		check(sample_o, 8'h5B);
		// Calibration counts as enabled all run: link goes up after it, down before it
		// Link disabled first, then configuration touched
		reg_wr(IDX_LINK_ENABLE, 8'h00);
		edges(2);
		check({link_rstn_o, serdes_pd_o, link_clk_en_o}, 3'b010);
		check(lmfc_count_o, 5'h00);
		@(posedge clk_i);
		sysref_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		sysref_i <= 1'b0;
		edges(6);
		check(lmfc_count_o, 5'h00);
		check(sample_o, 8'h00);
		reg_rd_chk(IDX_SYSTEM_STATUS, 8'h00);
		reg_wr(IDX_OUTPUT_MODE, 8'hFF);
		reg_rd_chk(IDX_OUTPUT_MODE, 8'h1F);
		reg_wr(IDX_TEST_PATTERN, 8'hAB);
		reg_rd_chk(IDX_TEST_PATTERN, 8'h0B);
		check(link_cfg_o.output_mode, 8'h1F);
		check(link_cfg_o.test_pattern, 8'h0B);
		reg_wr(IDX_LINK_ENABLE, 8'h01);
		edges(2);
		check({link_rstn_o, serdes_pd_o, link_clk_en_o}, 3'b101);
		check(sample_o, 8'h5B);
		reg_rd_chk(IDX_LINK_ENABLE, 8'h01);
		check(ila_cs_o, 2'h0);
		stop_test();
	end

endmodule // jesd_link_control_regs_tb
